// >>> design/hid_pkg.sv
package hid_pkg;
  localparam int WORD_W = 32;
  localparam int MEM_AW = 16;
  localparam int CNT_W = 15;
  localparam int PKT_W = 11;
  localparam int FRAME_W = 5;
  localparam int MASK_W = 8;
  localparam int RES_W = 3;
  localparam logic [2:0] W_DW0 = 3'h0;
  localparam logic [2:0] W_DW1 = 3'h1;
  localparam logic [2:0] W_DW2 = 3'h2;
  localparam logic [2:0] W_DW3 = 3'h3;
  localparam logic [2:0] W_DW4 = 3'h4;
  localparam int VALID_BIT = 0;
  localparam int TOTAL_LSB = 3;
  localparam int MPL_LSB = 18;
  localparam int MULT_LSB = 29;
  localparam int EP0_BIT = 31;
  localparam int EPH_LSB = 0;
  localparam int FADDR_LSB = 3;
  localparam int TOKEN_LSB = 10;
  localparam int SPLIT_BIT = 14;
  localparam int FRAME_LSB = 3;
  localparam int BUF_LSB = 8;
  localparam int DONE_LSB = 0;
  localparam int MASK_LSB = 0;
  localparam int RES_LSB = 8;
  localparam logic [1:0] TOKEN_OUT = 2'h0;
  localparam logic [1:0] TOKEN_IN = 2'h1;
  localparam logic [1:0] MULT_UNDEF = 2'h0;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0;
  localparam logic [MEM_AW-1:0] ADDR_RST = 16'h0;

  typedef struct packed {
    logic token_in;
    logic split;
    logic [6:0] function_addr;
    logic [3:0] endpoint_number;
    logic [MEM_AW-1:0] mem_addr;
    logic [PKT_W-1:0] len;
  } hid_txn_cmd_t;

  typedef struct packed {
    logic [PKT_W-1:0] bytes;
    logic xact_err;
    logic babble;
    logic underrun;
    logic fatal;
  } hid_txn_rsp_t;

  localparam hid_txn_cmd_t CMD_RST = '0;
endpackage : hid_pkg

// >>> design/hid_poll_match.sv
`timescale 1ns/100ps
`default_nettype none
module hid_poll_match
  import hid_pkg::*;
#(
  parameter int FIELD_W = FRAME_W
) (
  input wire logic [FIELD_W-1:0] frame_field,
  input wire logic [FIELD_W-1:0] bus_frame,
  output logic hit
);
  logic [FIELD_W-1:0] phase_mask;

  if (FIELD_W < 1) begin : g_chk
    $error("hid_poll_match: FIELD_W must be at least 1");
  end

  // period from top set bit
  // Smearing the top bit down gives period minus one; zero field hits every frame
  always_comb begin
    phase_mask = '0;
    for (int i = 0; i < FIELD_W; i++) begin
      phase_mask[i] = |(frame_field >> i);
    end
  end

  assign hit = ((frame_field ^ bus_frame) & phase_mask) == '0;
endmodule : hid_poll_match
`default_nettype wire

// >>> design/hid_exec.sv
`timescale 1ns/100ps
`default_nettype none
module hid_exec
  import hid_pkg::*;
#(
  parameter int MAX_MULT = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic exec_start,
  input wire logic [MEM_AW-1:0] desc_base,
  input wire logic [FRAME_W-1:0] bus_frame,
  input wire logic [2:0] bus_uframe,
  output logic exec_busy,
  output logic exec_done,
  output logic exec_skipped,
  output logic mem_req,
  output logic mem_we,
  output logic [MEM_AW-1:0] mem_addr,
  output logic [WORD_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [WORD_W-1:0] mem_rdata,
  output logic txn_req,
  output hid_txn_cmd_t txn_cmd,
  input wire logic txn_done,
  input wire hid_txn_rsp_t txn_rsp
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_READ = 3'h1,
    ST_CHECK = 3'h2,
    ST_ISSUE = 3'h3,
    ST_WAIT = 3'h4,
    ST_WBACK = 3'h5,
    ST_DONE = 3'h6
  } hid_state_t;

  if (MAX_MULT < 1 || MAX_MULT > 3) begin : g_chk
    $error("hid_exec: MAX_MULT must be 1 to 3");
  end

  hid_state_t state_reg;
  logic [WORD_W-1:0] dw_reg [5];
  logic [2:0] idx_reg;
  logic [MEM_AW-1:0] base_reg;
  logic [FRAME_W-1:0] frame_reg;
  logic [2:0] uf_reg;
  logic [CNT_W-1:0] count_reg;
  logic [RES_W-1:0] result_reg;
  logic [1:0] pkts_reg;
  logic clear_valid_reg;
  logic frame_hit;
  logic [CNT_W-1:0] total;
  logic [PKT_W-1:0] maxpkt;
  logic [1:0] mult;
  logic [MASK_W-1:0] uf_mask;
  logic [CNT_W:0] remain;
  logic [PKT_W-1:0] pkt_len;
  logic [CNT_W:0] count_sum;
  logic [WORD_W-1:0] dw3_new;
  logic [WORD_W-1:0] dw4_new;
  logic [WORD_W-1:0] dw0_new;
  logic last_pkt;

  assign total = dw_reg[W_DW0][TOTAL_LSB +: CNT_W];
  assign maxpkt = dw_reg[W_DW0][MPL_LSB +: PKT_W];
  assign mult = dw_reg[W_DW0][MULT_LSB +: 2];
  assign uf_mask = dw_reg[W_DW4][MASK_LSB +: MASK_W];
  assign remain = {1'b0, total} - {1'b0, count_reg};
  assign pkt_len = (remain > {{(CNT_W-PKT_W+1){1'b0}}, maxpkt}) ? maxpkt : remain[PKT_W-1:0];
  assign count_sum = {1'b0, count_reg} + {{(CNT_W-PKT_W+1){1'b0}}, txn_rsp.bytes};
  // done when total reached, short packet, fatal error, or last packet allowed by the multiplier
  assign last_pkt = txn_rsp.fatal || (count_sum >= {1'b0, total}) ||
                    (txn_rsp.bytes < txn_cmd.len) || (pkts_reg == 2'h1);

  // only hardware-owned bits change, the rest is written back unchanged
  assign dw3_new = {dw_reg[W_DW3][WORD_W-1:CNT_W], count_reg};
  // result stored in this microframe slot
  always_comb begin
    dw4_new = dw_reg[W_DW4];
    dw4_new[MASK_LSB + uf_reg] = 1'b0;
    dw4_new[RES_LSB + RES_W*uf_reg +: RES_W] = result_reg;
  end
  assign dw0_new = {dw_reg[W_DW0][WORD_W-1:1], 1'b0};

  hid_poll_match #(
    .FIELD_W(FRAME_W)
  ) u_match (
    .frame_field(dw_reg[W_DW2][FRAME_LSB +: FRAME_W]),
    .bus_frame(frame_reg),
    .hit(frame_hit)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      idx_reg <= W_DW0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (exec_start) begin
            state_reg <= ST_READ;
            idx_reg <= W_DW0;
          end
        end
        ST_READ: begin
          if (mem_ack) begin
            if (idx_reg == W_DW4) begin
              state_reg <= ST_CHECK;
            end else begin
              idx_reg <= idx_reg + 3'h1;
            end
          end
        end
        ST_CHECK: begin
          // only masked microframe in matching frame
          if (!dw_reg[W_DW0][VALID_BIT] || !frame_hit || !uf_mask[uf_reg]) begin
            state_reg <= ST_DONE;
          end else begin
            state_reg <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (count_reg >= total) begin
            state_reg <= ST_WBACK;
            idx_reg <= W_DW3;
          end else begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (txn_done) begin
            if (last_pkt) begin
              state_reg <= ST_WBACK;
              idx_reg <= W_DW3;
            end else begin
              state_reg <= ST_ISSUE;
            end
          end
        end
        ST_WBACK: begin
          if (mem_ack) begin
            if (idx_reg == W_DW3) begin
              idx_reg <= W_DW4;
            end else if (idx_reg == W_DW4 && clear_valid_reg) begin
              idx_reg <= W_DW0;
            end else begin
              state_reg <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Descriptor snapshot
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 5; i++) begin
        dw_reg[i] <= WORD_RST;
      end
      base_reg <= ADDR_RST;
      frame_reg <= '0;
      uf_reg <= '0;
    end else begin
      if (state_reg == ST_IDLE && exec_start) begin
        base_reg <= desc_base;
        frame_reg <= bus_frame;
        uf_reg <= bus_uframe;
      end
      if (state_reg == ST_READ && mem_ack) begin
        dw_reg[idx_reg] <= mem_rdata;
      end
    end
  end

  // Packet progress, count and result
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
      result_reg <= '0;
      pkts_reg <= 2'h0;
      clear_valid_reg <= 1'b0;
    end else begin
      if (state_reg == ST_CHECK) begin
        count_reg <= dw_reg[W_DW3][DONE_LSB +: CNT_W];
        result_reg <= '0;
        clear_valid_reg <= 1'b0;
        // up to multiplier packets; undefined value runs one
        pkts_reg <= (mult == MULT_UNDEF) ? 2'h1 :
                    ((int'(mult) > MAX_MULT) ? 2'(MAX_MULT) : mult);
      end else if (state_reg == ST_ISSUE && count_reg >= total) begin
        clear_valid_reg <= 1'b1;
      end else if (state_reg == ST_WAIT && txn_done) begin
        count_reg <= count_sum[CNT_W-1:0];
        pkts_reg <= pkts_reg - 2'h1;
        result_reg <= result_reg | {txn_rsp.underrun, txn_rsp.babble, txn_rsp.xact_err};
        // completion or fatal error ends validity
        if (txn_rsp.fatal || count_sum >= {1'b0, total} || txn_rsp.bytes < txn_cmd.len) begin
          clear_valid_reg <= 1'b1;
        end
      end
    end
  end

  // Buffer memory port
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= ADDR_RST;
      mem_wdata <= WORD_RST;
    end else begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      if (state_reg == ST_READ && !(mem_ack && idx_reg == W_DW4)) begin
        mem_req <= 1'b1;
        mem_addr <= base_reg + MEM_AW'(mem_ack ? idx_reg + 3'h1 : idx_reg);
      end else if (state_reg == ST_WBACK &&
                   !(mem_ack && (idx_reg == W_DW0 || (idx_reg == W_DW4 && !clear_valid_reg)))) begin
        mem_req <= 1'b1;
        mem_we <= 1'b1;
        if (mem_ack && idx_reg == W_DW3) begin
          mem_addr <= base_reg + MEM_AW'(W_DW4);
          mem_wdata <= dw4_new;
        end else if (mem_ack) begin
          mem_addr <= base_reg + MEM_AW'(W_DW0);
          mem_wdata <= dw0_new;
        end else begin
          mem_addr <= base_reg + MEM_AW'(idx_reg);
          mem_wdata <= (idx_reg == W_DW3) ? dw3_new : ((idx_reg == W_DW4) ? dw4_new : dw0_new);
        end
      end
    end
  end

  // Transaction request toward the packet engine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txn_req <= 1'b0;
      txn_cmd <= CMD_RST;
    end else begin
      txn_req <= 1'b0;
      if (state_reg == ST_ISSUE && count_reg < total) begin
        txn_req <= 1'b1;
        txn_cmd.token_in <= (dw_reg[W_DW1][TOKEN_LSB +: 2] == TOKEN_IN);
        txn_cmd.split <= dw_reg[W_DW1][SPLIT_BIT];
        txn_cmd.function_addr <= dw_reg[W_DW1][FADDR_LSB +: 7];
        txn_cmd.endpoint_number <= {dw_reg[W_DW1][EPH_LSB +: 3], dw_reg[W_DW0][EP0_BIT]};
        // internal memory address in 8-byte units
        txn_cmd.mem_addr <= dw_reg[W_DW2][BUF_LSB +: MEM_AW] + MEM_AW'(count_reg >> 3);
        txn_cmd.len <= pkt_len;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      exec_busy <= 1'b0;
      exec_done <= 1'b0;
      exec_skipped <= 1'b0;
    end else begin
      exec_busy <= (state_reg != ST_IDLE) || exec_start;
      exec_done <= (state_reg == ST_DONE);
      exec_skipped <= (state_reg == ST_CHECK) && !dw_reg[W_DW0][VALID_BIT];
    end
  end

  AST_TOKEN: assert property (@(posedge clk) disable iff (!rst_b)
    txn_req |-> txn_cmd.token_in == (dw_reg[W_DW1][TOKEN_LSB +: 2] == TOKEN_IN))
    else $error("token differs from descriptor");
  AST_MAXPKT: assert property (@(posedge clk) disable iff (!rst_b)
    txn_req |-> txn_cmd.len <= maxpkt && txn_cmd.len != '0)
    else $error("packet longer than max packet bytes");
  AST_TOTAL: assert property (@(posedge clk) disable iff (!rst_b)
    txn_req |-> ({1'b0, count_reg} + {5'h0, txn_cmd.len}) <= {1'b0, total})
    else $error("packet passes total payload");
  AST_FADDR: assert property (@(posedge clk) disable iff (!rst_b)
    txn_req |-> txn_cmd.function_addr == dw_reg[W_DW1][FADDR_LSB +: 7])
    else $error("wrong function address");
  AST_EP: assert property (@(posedge clk) disable iff (!rst_b)
    txn_req |-> txn_cmd.endpoint_number == {dw_reg[W_DW1][2:0], dw_reg[W_DW0][31]})
    else $error("wrong endpoint number");
  AST_SPLIT: assert property (@(posedge clk) disable iff (!rst_b)
    txn_req |-> txn_cmd.split == dw_reg[W_DW1][SPLIT_BIT])
    else $error("split flag differs");
  AST_UFRAME: assert property (@(posedge clk) disable iff (!rst_b)
    txn_req |-> uf_mask[uf_reg] && frame_hit && dw_reg[W_DW0][VALID_BIT])
    else $error("transaction outside selected microframe");
  AST_SKIP: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_CHECK && !dw_reg[W_DW0][VALID_BIT]) |=> (!mem_we && !txn_req) [*3])
    else $error("skipped descriptor touched");
  AST_VALID: assert property (@(posedge clk) disable iff (!rst_b)
    (mem_we && mem_addr == base_reg) |-> mem_wdata == {dw_reg[W_DW0][31:1], 1'b0} && clear_valid_reg)
    else $error("bad valid write back");
  AST_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
    (mem_we && mem_addr == base_reg + 16'h3) |-> mem_wdata[CNT_W-1:0] == count_reg)
    else $error("bad transferred count");
  AST_ONEPKT: assert property (@(posedge clk) disable iff (!rst_b)
    txn_req |=> !txn_req)
    else $error("back to back packet requests");
endmodule : hid_exec
`default_nettype wire

// >>> verif/hid_ep_model.sv
`timescale 1ns/100ps
`default_nettype none
module hid_ep_model
  import hid_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic short_pkt,
  input wire logic [3:0] flags,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [MEM_AW-1:0] mem_addr,
  input wire logic [WORD_W-1:0] mem_wdata,
  output logic mem_ack,
  output logic [WORD_W-1:0] mem_rdata,
  input wire logic txn_req,
  input wire hid_txn_cmd_t txn_cmd,
  output logic txn_done,
  output hid_txn_rsp_t txn_rsp
);
  logic [WORD_W-1:0] mem [0:7];
  logic [1:0] mcnt;
  logic [1:0] tcnt;
  logic tbusy;
  // Outside the ack cycle the data lines are scrambled, never the last value
  assign mem_rdata = mem_ack ? mem[mem_addr[2:0]] : ~mem[mem_addr[2:0]];
  assign txn_rsp = txn_done ? {txn_cmd.len - PKT_W'(short_pkt), flags} : ~{txn_cmd.len, flags};
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      mcnt <= 2'h0;
      txn_done <= 1'b0;
      tbusy <= 1'b0;
      tcnt <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      txn_done <= 1'b0;
      if (mem_req && !mem_ack) begin
        if (mcnt >= {slow, 1'b0}) begin
          mem_ack <= 1'b1;
          mcnt <= 2'h0;
          if (mem_we) begin
            mem[mem_addr[2:0]] <= mem_wdata;
          end
        end else begin
          mcnt <= mcnt + 2'h1;
        end
      end
      if (txn_req) begin
        tbusy <= 1'b1;
        tcnt <= 2'h0;
      end else if (tbusy && tcnt >= {slow, 1'b0}) begin
        txn_done <= 1'b1;
        tbusy <= 1'b0;
      end else if (tbusy) begin
        tcnt <= tcnt + 2'h1;
      end
    end
  end
endmodule : hid_ep_model
`default_nettype wire

// >>> verif/tb_hs_interrupt_descriptor_exec.sv
`timescale 1ns/100ps
`default_nettype none
module tb_hs_interrupt_descriptor_exec;
  import hid_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic exec_start = 1'b0;
  logic slow = 1'b0;
  logic short_pkt = 1'b0;
  logic [3:0] flags = 4'h0;
  logic [MEM_AW-1:0] desc_base = 16'h0;
  logic [FRAME_W-1:0] bus_frame = 5'h0;
  logic [2:0] bus_uframe = 3'h0;
  logic exec_busy, exec_done, exec_skipped, mem_req, mem_we, mem_ack, txn_req, txn_done;
  logic [MEM_AW-1:0] mem_addr;
  logic [WORD_W-1:0] mem_wdata, mem_rdata;
  hid_txn_cmd_t txn_cmd;
  hid_txn_rsp_t txn_rsp;
  logic [31:0] seed = 32'hc151;
  logic [31:0] r, q;
  logic [31:0] d [0:4];
  logic [31:0] e [0:4];
  logic [14:0] e_cnt = 15'h0;
  int n_fail = 0;
  int cmp_count = 0;
  int n_txn = 0;
  int n_wr = 0;
  int n_skip = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  hid_exec hid_exec_i (.clk, .rst_b, .exec_start, .desc_base, .bus_frame, .bus_uframe,
    .exec_busy, .exec_done, .exec_skipped, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata, .txn_req, .txn_cmd, .txn_done, .txn_rsp);
  hid_ep_model hid_ep_model_i (.clk, .rst_b, .slow, .short_pkt, .flags, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .txn_req, .txn_cmd, .txn_done, .txn_rsp);
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  function automatic logic [15:0] buf_start(input logic [31:0] cpu);
    return 16'((cpu - 32'h400) >> 3);
  endfunction : buf_start
  // legal mask patterns
  // One bit only once the frame field is nonzero
  function automatic logic [7:0] pick_mask(input logic [7:0] s, input logic ms);
    case ({ms, s[1:0]})
      3'h0: return 8'hff;
      3'h1: return s[2] ? 8'haa : 8'h55;
      3'h2: return 8'h11 << s[3:2];
      default: return 8'h01 << s[4:2];
    endcase
  endfunction : pick_mask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [39:0] ex, input logic [39:0] got);
    cmp_count++;
    if (got !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  function automatic hid_txn_cmd_t exp_cmd();
    logic [14:0] left;
    hid_txn_cmd_t c;
    left = d[0][17:3] - e_cnt;
    c.token_in = (d[1][11:10] == TOKEN_IN);
    c.split = d[1][SPLIT_BIT];
    c.function_addr = d[1][9:3];
    c.endpoint_number = {d[1][2:0], d[0][EP0_BIT]};
    c.mem_addr = d[2][23:8] + 16'(e_cnt >> 3);
    c.len = (left < 15'(d[0][28:18])) ? 11'(left) : d[0][28:18];
    return c;
  endfunction : exp_cmd
  // Predicted write-back; the endpoint returns the same flags for every packet
  task automatic expect_wb(input logic [2:0] uf, input logic [4:0] bf, output int np,
    output int nw);
    logic [14:0] tot, cnt;
    logic [10:0] len, by;
    logic [2:0] res;
    logic clr;
    int nm;
    tot = d[0][17:3];
    cnt = d[3][14:0];
    nm = (d[0][30:29] == MULT_UNDEF) ? 1 : int'(d[0][30:29]);
    res = 3'h0;
    clr = 1'b0;
    np = 0;
    nw = 0;
    for (int i = 0; i < 5; i++) e[i] = d[i];
    if (!(d[0][0] && d[4][uf] && (d[2][7:3] == 5'h0 || bf[0]))) return;
    for (int k = 0; k < nm && !clr; k++) begin
      len = (tot - cnt < 15'(d[0][28:18])) ? 11'(tot - cnt) : d[0][28:18];
      by = len - 11'(short_pkt);
      cnt = cnt + 15'(by);
      np++;
      res = res | {flags[1], flags[2], flags[3]};
      clr = flags[0] || cnt >= tot || by < len;
    end
    e[3][14:0] = cnt;
    e[4][uf] = 1'b0;
    e[4][8 + 3 * uf +: 3] = res;
    e[0][0] = !clr;
    nw = clr ? 3 : 2;
  endtask : expect_wb
  task automatic run(input logic [2:0] uf, input logic [4:0] bf);
    int np, nw;
    logic dn;
    for (int i = 0; i < 5; i++) hid_ep_model_i.mem[i] = d[i];
    e_cnt = d[3][14:0];
    n_txn = 0;
    n_wr = 0;
    n_skip = 0;
    dn = 1'b0;
    q = rnd();
    repeat (2) @(posedge clk);
    // Model inputs have settled by now, so the prediction sees them
    expect_wb(uf, bf, np, nw);
    bus_uframe <= uf;
    bus_frame <= bf;
    desc_base <= {q[15:3], 3'h0};
    exec_start <= 1'b1;
    @(posedge clk);
    exec_start <= 1'b0;
    @(negedge clk);
    chk("exec_busy", 40'h1, 40'(exec_busy));
    repeat (300) if (!dn) begin
      @(posedge clk);
      dn = (exec_done === 1'b1);
    end
    chk("exec_done", 40'h1, 40'(dn));
    chk("txn_count", 40'(np), 40'(n_txn));
    chk("write_count", 40'(nw), 40'(n_wr));
    chk("skip", 40'(!d[0][0]), 40'(n_skip));
    for (int i = 0; i < 5; i++) chk("desc_word", 40'(e[i]), 40'(hid_ep_model_i.mem[i]));
  endtask : run
  task automatic one(input logic [1:0] m, input logic [10:0] p, input logic [14:0] t,
    input logic v, input logic [7:0] k, input logic [4:0] fr, input logic [2:0] uf,
    input logic [4:0] bf, input logic [3:0] fl, input logic sh);
    flags <= fl;
    short_pkt <= sh;
    r = rnd();
    // descriptor as software lays it out
    d[0] = {r[0], m, p, t, 2'h0, v};
    d[1] = {17'h0, r[1], 2'h3, 1'b0, r[2], r[9:3], r[12:10]};
    d[2] = {8'h0, buf_start(32'h400 + {13'h0, r[28:13], 3'h0}), fr, 3'h0};
    d[3] = {r[31:29], 29'h0};
    d[4] = {24'h0, k};
    run(uf, bf);
  endtask : one
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      print_verdict();
    end
    if (txn_req) n_txn++;
    if (txn_req) chk("txn_cmd", exp_cmd(), txn_cmd);
    if (txn_done) e_cnt = e_cnt + 15'(txn_rsp.bytes);
    if (exec_skipped) n_skip++;
    if (mem_req && mem_ack && mem_we) n_wr++;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    one(2'h1, 11'h8, 15'h8, 1'b0, 8'hff, 5'h0, 3'h0, 5'h0, 4'h0, 1'b0);
    one(2'h1, 11'h8, 15'h8, 1'b1, 8'h01, 5'h0, 3'h3, 5'h0, 4'h0, 1'b0);
    one(2'h1, 11'h8, 15'h8, 1'b1, 8'hff, 5'h1, 3'h2, 5'h0, 4'h0, 1'b0);
    one(2'h1, 11'h8, 15'h8, 1'b1, 8'hff, 5'h1, 3'h2, 5'h1, 4'h0, 1'b0);
    one(2'h3, 11'h8, 15'h14, 1'b1, 8'hff, 5'h0, 3'h5, 5'h0, 4'h0, 1'b0);
    one(2'h0, 11'h8, 15'h14, 1'b1, 8'hff, 5'h0, 3'h1, 5'h0, 4'h0, 1'b0);
    one(2'h2, 11'h8, 15'h14, 1'b1, 8'hff, 5'h0, 3'h7, 5'h0, 4'h1, 1'b0);
    one(2'h2, 11'h8, 15'h14, 1'b1, 8'hff, 5'h0, 3'h4, 5'h0, 4'he, 1'b0);
    one(2'h3, 11'h8, 15'h14, 1'b1, 8'hff, 5'h0, 3'h6, 5'h0, 4'h0, 1'b1);
    one(2'h1, 11'h7ff, 15'h7fff, 1'b1, 8'h80, 5'h0, 3'h7, 5'h0, 4'h0, 1'b0);
    repeat (40) begin
      q = rnd();
      slow <= q[9];
      one((q[11:10] == 2'h0) ? 2'h1 : q[11:10], 11'(q[19:12]) + 11'h1,
        15'(q[29:20]) + 15'h1, q[31] | q[30], pick_mask(seed[7:0], seed[8]), {4'h0, seed[8]},
        seed[11:9], seed[16:12], (q[3:0] == 4'h0) ? 4'h1 : {q[6:4], 1'b0}, q[7] & q[8]);
    end
    print_verdict();
  end
endmodule : tb_hs_interrupt_descriptor_exec
`default_nettype wire
